// *** design/uip_pkg.sv ***
package uip_pkg;
  typedef enum logic [2:0] {
    parity_off,
    parity_even_sel,
    parity_odd_sel,
    parity_forced_one,
    parity_forced_zero
  } uip_parity_t;
  typedef enum logic {
    tx_irq_on_threshold,
    tx_irq_on_idle
  } uip_txmode_t;
  typedef struct packed {
    uip_parity_t parity;
    uip_txmode_t txmode;
    logic [2:0] tx_thr;
    logic [2:0] rx_thr;
  } uip_ctrl_t;
  typedef struct packed {
    logic [7:0] data;
    logic parity_bit;
    logic framing;
    logic brk;
  } uip_rx_head_t;
  typedef struct packed {
    logic [7:0] data;
    logic parity_bit;
  } uip_tx_push_t;
  typedef struct packed {
    logic dsr;
    logic dcd;
    logic cts;
    logic ri;
  } uip_modem_t;
endpackage : uip_pkg

// *** design/uip_regs.svh ***
`ifndef UIP_REGS_SVH
`define UIP_REGS_SVH
`define UIP_OFF_DATA 8'h00
`define UIP_OFF_RXERR 8'h04
`define UIP_OFF_STAT 8'h08
`define UIP_OFF_CTRL 8'h0c
`define UIP_OFF_IMASK 8'h10
`define UIP_OFF_RIS 8'h14
`define UIP_OFF_MIS 8'h18
`define UIP_NUM_IRQ 11
`define UIP_IRQ_RI 0
`define UIP_IRQ_CTS 1
`define UIP_IRQ_DCD 2
`define UIP_IRQ_DSR 3
`define UIP_IRQ_RX 4
`define UIP_IRQ_TX 5
`define UIP_IRQ_RT 6
`define UIP_IRQ_FE 7
`define UIP_IRQ_PE 8
`define UIP_IRQ_BE 9
`define UIP_IRQ_OE 10
`define UIP_RXERR_FE 0
`define UIP_RXERR_PE 1
`define UIP_RXERR_BE 2
`define UIP_RXERR_OE 3
`define UIP_DATA_ERR_LSB 8
`define UIP_STAT_TXSPACE 0
`define UIP_STAT_RXEMPTY 1
`define UIP_STAT_TXIDLE 2
`define UIP_CTRL_PAR_LSB 0
`define UIP_CTRL_TXMODE 3
`define UIP_CTRL_TXTHR_LSB 4
`define UIP_CTRL_RXTHR_LSB 8
`define UIP_THR_1_8 3'h0
`define UIP_THR_2_8 3'h1
`define UIP_THR_4_8 3'h2
`define UIP_THR_6_8 3'h3
`define UIP_THR_7_8 3'h4
`define UIP_RST_THR 3'h2
`define UIP_RST_IMASK 11'h000
`define UIP_RESP_OKAY 2'h0
`define UIP_RESP_SLVERR 2'h2
`endif

// *** design/uip_status.sv ***
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "uip_regs.svh"
// Behaviour
// R01 - Each source has its own enable bit
// R02 - Eleven maskable interrupt sources exist
// R03 - Raw and masked interrupt status readable
// R04 - Parity none, even, odd, forced one, zero
// R05 - Four receive error flags, cleared together
// R06 - Overrun immediate; others follow last read
// R07 - Host clears error status after interrupt
// R08 - Transmit FIFO free-space flag is readable
// R09 - Transmit irq defaults to threshold; mode readable
// R10 - Idle mode: FIFO empty, frame fully sent
// R11 - Separate tx and rx thresholds, five levels
// R12 - Write-one clears chosen pending sources
// R13 - Interrupt output is OR of masked bits
module uip_status #(
  parameter int FIFO_DEPTH = 16,
  parameter int LVL_W = $clog2(FIFO_DEPTH) + 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uip_pkg::uip_rx_head_t rx_head,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic rx_overrun_pulse,
  input wire logic rx_timeout_pulse,
  output logic rx_pop,
  input wire logic [LVL_W-1:0] tx_level,
  input wire logic tx_shift_busy,
  output logic tx_push,
  output uip_pkg::uip_tx_push_t tx_push_word,
  output uip_pkg::uip_parity_t parity_mode,
  input wire uip_pkg::uip_modem_t modem_pins,
  output logic irq
);
  localparam int NI = `UIP_NUM_IRQ;

  if (FIFO_DEPTH < 8 || FIFO_DEPTH % 8 != 0 || LVL_W < $clog2(FIFO_DEPTH) + 1) begin : g_chk
    $error("FIFO_DEPTH must be a multiple of eight and LVL_W must hold it");
  end

  // Fill level that a threshold code selects
  function automatic logic [LVL_W-1:0] thr_lvl(input logic [2:0] sel);
    int n;
    case (sel)
      `UIP_THR_1_8: n = FIFO_DEPTH / 8;
      `UIP_THR_2_8: n = FIFO_DEPTH / 4;
      `UIP_THR_6_8: n = FIFO_DEPTH * 3 / 4;
      `UIP_THR_7_8: n = FIFO_DEPTH * 7 / 8;
      default: n = FIFO_DEPTH / 2;
    endcase
    return LVL_W'(n);
  endfunction : thr_lvl

  function automatic logic par_bit(input uip_pkg::uip_parity_t p, input logic [7:0] d);
    case (p)
      uip_pkg::parity_even_sel: return ^d;
      uip_pkg::parity_odd_sel: return ~^d;
      uip_pkg::parity_forced_one: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : par_bit

  uip_pkg::uip_ctrl_t ctrl_q;
  logic [NI-1:0] imask_q;
  logic [NI-1:0] ris_q;
  logic [3:0] rxerr_q;
  logic [3:0] rxerr_prev_q;
  logic [3:0] m_s1_q;
  logic [3:0] m_s2_q;
  logic [3:0] m_s3_q;
  logic rx_cond_q;
  logic tx_cond_q;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;

  logic wr_fire;
  logic [31:0] wbits;
  logic wr_ok;
  logic rd_fire;
  logic [31:0] rd_word;
  logic rd_ok;
  logic rx_nonempty;
  logic head_pe;
  logic tx_idle;
  logic rx_cond;
  logic tx_cond;
  logic [NI-1:0] evt;
  logic [NI-1:0] ris_clr;
  logic rd_data_pop;
  logic rxerr_clr;

  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wbits = wr_data_q & {{8{wr_strb_q[3]}}, {8{wr_strb_q[2]}},
                              {8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rx_nonempty = rx_level != '0;
  assign tx_idle = tx_level == '0 && !tx_shift_busy; // R10
  assign head_pe = ctrl_q.parity != uip_pkg::parity_off &&
                   rx_head.parity_bit != par_bit(ctrl_q.parity, rx_head.data); // R04
  assign rd_data_pop = rd_fire && {s_axi_araddr[7:2], 2'b00} == `UIP_OFF_DATA && rx_nonempty;
  assign rxerr_clr = wr_fire && {wr_addr_q[7:2], 2'b00} == `UIP_OFF_RXERR;
  assign rx_cond = rx_level >= thr_lvl(ctrl_q.rx_thr); // R11
  assign tx_cond = ctrl_q.txmode == uip_pkg::tx_irq_on_idle ? tx_idle : // R10
                   tx_level <= thr_lvl(ctrl_q.tx_thr); // R09 R11

  // Writable registers all sit at or below RIS; STAT is read-only
  always_comb begin
    wr_ok = 1'b0;
    if ({wr_addr_q[7:2], 2'b00} <= `UIP_OFF_RIS) begin
      wr_ok = {wr_addr_q[7:2], 2'b00} != `UIP_OFF_STAT;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if ({s_axi_araddr[7:2], 2'b00} == `UIP_OFF_DATA) begin
      if (rx_nonempty) begin
        rd_word[7:0] = rx_head.data;
        rd_word[`UIP_DATA_ERR_LSB +: 3] = {rx_head.brk, head_pe, rx_head.framing};
      end
    end else if ({s_axi_araddr[7:2], 2'b00} == `UIP_OFF_RXERR) begin
      rd_word[3:0] = rxerr_q; // R05
    end else if ({s_axi_araddr[7:2], 2'b00} == `UIP_OFF_STAT) begin
      rd_word[`UIP_STAT_TXSPACE] = tx_level < LVL_W'(FIFO_DEPTH); // R08
      rd_word[`UIP_STAT_RXEMPTY] = !rx_nonempty;
      rd_word[`UIP_STAT_TXIDLE] = tx_idle;
    end else if ({s_axi_araddr[7:2], 2'b00} == `UIP_OFF_CTRL) begin
      rd_word[`UIP_CTRL_PAR_LSB +: 3] = ctrl_q.parity;
      rd_word[`UIP_CTRL_TXMODE] = ctrl_q.txmode; // R09
      rd_word[`UIP_CTRL_TXTHR_LSB +: 3] = ctrl_q.tx_thr;
      rd_word[`UIP_CTRL_RXTHR_LSB +: 3] = ctrl_q.rx_thr;
    end else if ({s_axi_araddr[7:2], 2'b00} == `UIP_OFF_IMASK) begin
      rd_word[NI-1:0] = imask_q;
    end else if ({s_axi_araddr[7:2], 2'b00} == `UIP_OFF_RIS) begin
      rd_word[NI-1:0] = ris_q; // R03
    end else if ({s_axi_araddr[7:2], 2'b00} == `UIP_OFF_MIS) begin
      rd_word[NI-1:0] = ris_q & imask_q; // R03
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Write channel: address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UIP_RESP_OKAY;
      wr_addr_q <= 8'h00;
      wr_data_q <= 32'h0000_0000;
      wr_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `UIP_RESP_OKAY : `UIP_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read data is captured at the address handshake so side effects happen once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `UIP_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `UIP_RESP_OKAY : `UIP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Illegal mode or threshold codes are ignored so the fields stay decodable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q.parity <= uip_pkg::parity_off;
      ctrl_q.txmode <= uip_pkg::tx_irq_on_threshold; // R09
      ctrl_q.tx_thr <= `UIP_RST_THR;
      ctrl_q.rx_thr <= `UIP_RST_THR;
      imask_q <= `UIP_RST_IMASK;
    end else if (wr_fire && {wr_addr_q[7:2], 2'b00} == `UIP_OFF_CTRL) begin
      if (wr_strb_q[0]) begin
        if (wr_data_q[`UIP_CTRL_PAR_LSB +: 3] <= 3'h4) begin
          ctrl_q.parity <= uip_pkg::uip_parity_t'(wr_data_q[`UIP_CTRL_PAR_LSB +: 3]); // R04
        end
        ctrl_q.txmode <= uip_pkg::uip_txmode_t'(wr_data_q[`UIP_CTRL_TXMODE]);
        if (wr_data_q[`UIP_CTRL_TXTHR_LSB +: 3] <= `UIP_THR_7_8) begin
          ctrl_q.tx_thr <= wr_data_q[`UIP_CTRL_TXTHR_LSB +: 3]; // R11
        end
      end
      if (wr_strb_q[1] && wr_data_q[`UIP_CTRL_RXTHR_LSB +: 3] <= `UIP_THR_7_8) begin
        ctrl_q.rx_thr <= wr_data_q[`UIP_CTRL_RXTHR_LSB +: 3]; // R11
      end
    end else if (wr_fire && {wr_addr_q[7:2], 2'b00} == `UIP_OFF_IMASK) begin
      imask_q <= (imask_q & ~{wr_strb_q[1] ? 3'h7 : 3'h0, wr_strb_q[0] ? 8'hff : 8'h00})
                 | wbits[NI-1:0]; // R01
    end
  end

  assign parity_mode = ctrl_q.parity;

  // Push to the transmit FIFO with the parity bit already formed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_push <= 1'b0;
      tx_push_word <= '0;
      rx_pop <= 1'b0;
    end else begin
      tx_push <= wr_fire && {wr_addr_q[7:2], 2'b00} == `UIP_OFF_DATA && wr_strb_q[0]
                 && tx_level < LVL_W'(FIFO_DEPTH);
      tx_push_word.data <= wr_data_q[7:0];
      tx_push_word.parity_bit <= par_bit(ctrl_q.parity, wr_data_q[7:0]); // R04
      rx_pop <= rd_data_pop;
    end
  end

  // Error flags: a new error in the clearing cycle wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxerr_q <= 4'h0;
    end else begin
      if (rxerr_clr) begin
        rxerr_q <= 4'h0; // R05
      end
      if (rd_data_pop) begin
        rxerr_q[`UIP_RXERR_FE] <= rx_head.framing; // R06
        rxerr_q[`UIP_RXERR_PE] <= head_pe; // R06
        rxerr_q[`UIP_RXERR_BE] <= rx_head.brk; // R06
      end
      if (rx_overrun_pulse) begin
        rxerr_q[`UIP_RXERR_OE] <= 1'b1; // R06
      end
    end
  end

  // Modem lines come from pins: two flops, then a third for change detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      m_s1_q <= 4'h0;
      m_s2_q <= 4'h0;
      m_s3_q <= 4'h0;
    end else begin
      m_s1_q <= modem_pins;
      m_s2_q <= m_s1_q;
      m_s3_q <= m_s2_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxerr_prev_q <= 4'h0;
      rx_cond_q <= 1'b0;
      tx_cond_q <= 1'b1; // Empty FIFO at reset is no fresh drop
    end else begin
      rxerr_prev_q <= rxerr_q;
      rx_cond_q <= rx_cond;
      tx_cond_q <= tx_cond;
    end
  end

  // Error interrupts fire on a flag rising, so software must clear the flags
  always_comb begin
    evt = '0;
    evt[`UIP_IRQ_DSR:`UIP_IRQ_RI] = m_s2_q ^ m_s3_q; // R02
    evt[`UIP_IRQ_RX] = rx_cond && !rx_cond_q; // R02
    evt[`UIP_IRQ_TX] = tx_cond && !tx_cond_q; // R09 R10
    evt[`UIP_IRQ_RT] = rx_timeout_pulse; // R02
    evt[`UIP_IRQ_FE] = rxerr_q[`UIP_RXERR_FE] && !rxerr_prev_q[`UIP_RXERR_FE]; // R07
    evt[`UIP_IRQ_PE] = rxerr_q[`UIP_RXERR_PE] && !rxerr_prev_q[`UIP_RXERR_PE]; // R07
    evt[`UIP_IRQ_BE] = rxerr_q[`UIP_RXERR_BE] && !rxerr_prev_q[`UIP_RXERR_BE]; // R07
    evt[`UIP_IRQ_OE] = rxerr_q[`UIP_RXERR_OE] && !rxerr_prev_q[`UIP_RXERR_OE]; // R07
  end

  assign ris_clr = (wr_fire && {wr_addr_q[7:2], 2'b00} == `UIP_OFF_RIS) ? wbits[NI-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ris_q <= '0;
    end else begin
      ris_q <= (ris_q & ~ris_clr) | evt; // R12
    end
  end

  // Registered for a clean output; lags the status by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ris_q & imask_q); // R01 R13
    end
  end
endmodule : uip_status

// *** tb/test_uip_status.sv ***
`timescale 1ns/10ps
`include "uip_regs.svh"
module test_uip_status;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [4:0] rx_level, tx_level;
  logic rx_overrun_pulse, rx_timeout_pulse, rx_pop, tx_shift_busy, tx_push, irq;
  logic rx_in_vld, tx_drain;
  uip_pkg::uip_rx_head_t rx_head, rx_in;
  uip_pkg::uip_tx_push_t tx_push_word, pushed;
  uip_pkg::uip_parity_t parity_mode;
  uip_pkg::uip_modem_t modem_pins;
  int err_total, checks_done, pcnt;
  localparam logic [4:0] PBIT = 5'b01010;
  uip_status DUT (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rx_head(rx_head),
    .rx_level(rx_level),
    .rx_overrun_pulse(rx_overrun_pulse),
    .rx_timeout_pulse(rx_timeout_pulse),
    .rx_pop(rx_pop),
    .tx_level(tx_level),
    .tx_shift_busy(tx_shift_busy),
    .tx_push(tx_push),
    .tx_push_word(tx_push_word),
    .parity_mode(parity_mode),
    .modem_pins(modem_pins),
    .irq(irq)
  );
  uip_core_model u_core (
    .aclk(aclk),
    .aresetn(aresetn),
    .rx_pop(rx_pop),
    .tx_push(tx_push),
    .rx_in(rx_in),
    .rx_in_vld(rx_in_vld),
    .tx_drain(tx_drain),
    .rx_head(rx_head),
    .rx_level(rx_level),
    .tx_level(tx_level),
    .tx_shift_busy(tx_shift_busy)
  );
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Sampled mid-cycle, clear of the edge that launches the push
  always @(negedge aclk) begin
    if (tx_push) begin
      pushed = tx_push_word;
      pcnt++;
    end
  end
  task automatic close_out();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic hang(input int n);
    if (n >= 50) begin
      err_total++;
      close_out();
    end
  endtask : hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    hang(n);
    resp = s_axi_bresp;
  endtask : wr
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] m, e);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    hang(n);
    resp = s_axi_rresp;
    chk(nm, s_axi_rdata & m, e);
  endtask : rc
  task automatic put_rx(input logic [10:0] c);
    rx_in <= c;
    rx_in_vld <= 1'b1;
    @(posedge aclk);
    rx_in_vld <= 1'b0;
    @(posedge aclk);
  endtask : put_rx
  initial begin
    aresetn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, rx_in_vld, tx_drain} <= '0;
    {rx_overrun_pulse, rx_timeout_pulse, s_axi_awaddr, s_axi_araddr} <= '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} <= 6'h3f;
    {s_axi_wdata, rx_in, modem_pins} <= '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc("ctrl_rst", `UIP_OFF_CTRL, 32'h7ff, 32'h220);
    rc("imask_rst", `UIP_OFF_IMASK, 32'h7ff, 32'h0);
    wr(8'h40, 32'h7ff);
    chk("unmapped", 32'(resp), 32'h2);
    rc("unmapped_rd", 8'h40, 32'hffff_ffff, 32'h0);
    chk("unmapped_rresp", 32'(resp), 32'h2);
    for (int i = 0; i < 5; i++) begin
      wr(`UIP_OFF_CTRL, 32'h220 | 32'(i));
      chk("parity", 32'(parity_mode), 32'(i));
      wr(`UIP_OFF_DATA, 32'h5b);
      if (i > 0) chk("pbit", 32'(pushed.parity_bit), 32'(PBIT[i]));
    end
    wr(`UIP_OFF_CTRL, 32'h225);
    chk("par_bad", 32'(parity_mode), 32'h4);
    chk("bresp_ok", 32'(resp), 32'h0);
    wr(`UIP_OFF_CTRL, 32'h228);
    rc("mode", `UIP_OFF_CTRL, 32'h7ff, 32'h228);
    chk("rresp_ok", 32'(resp), 32'h0);
    wr(`UIP_OFF_CTRL, 32'h221);
    wr(`UIP_OFF_RIS, 32'h7ff);
    put_rx({8'h5b, 3'b010});
    rc("data", `UIP_OFF_DATA, 32'h7ff, 32'h35b);
    rc("rxerr", `UIP_OFF_RXERR, 32'hf, 32'h3);
    rx_overrun_pulse <= 1'b1;
    @(posedge aclk);
    rx_overrun_pulse <= 1'b0;
    rc("rxerr_ovr", `UIP_OFF_RXERR, 32'hf, 32'hb);
    rc("ris_err", `UIP_OFF_RIS, 32'h780, 32'h580);
    rc("mis_off", `UIP_OFF_MIS, 32'h7ff, 32'h0);
    chk("irq_off", 32'(irq), 32'h0);
    wr(`UIP_OFF_IMASK, 32'h80);
    rc("mis", `UIP_OFF_MIS, 32'h7ff, 32'h80);
    chk("irq_on", 32'(irq), 32'h1);
    wr(`UIP_OFF_RIS, 32'h80);
    rc("ris_w1c", `UIP_OFF_RIS, 32'h780, 32'h500);
    chk("irq_clr", 32'(irq), 32'h0);
    wr(`UIP_OFF_RXERR, 32'h0);
    rc("rxerr_clr", `UIP_OFF_RXERR, 32'hf, 32'h0);
    put_rx({8'h5b, 3'b110});
    rc("data2", `UIP_OFF_DATA, 32'h7ff, 32'h15b);
    rc("ris_again", `UIP_OFF_RIS, 32'h80, 32'h80);
    wr(`UIP_OFF_RIS, 32'h7ff);
    modem_pins <= 4'hf;
    rx_timeout_pulse <= 1'b1;
    @(posedge aclk);
    rx_timeout_pulse <= 1'b0;
    repeat (6) @(posedge aclk);
    rc("ris_evt", `UIP_OFF_RIS, 32'h4f, 32'h4f);
    wr(`UIP_OFF_CTRL, 32'h020);
    wr(`UIP_OFF_RIS, 32'h7ff);
    put_rx(11'h0);
    rc("rx_lvl1", `UIP_OFF_RIS, 32'h10, 32'h0);
    put_rx(11'h0);
    rc("rx_lvl2", `UIP_OFF_RIS, 32'h10, 32'h10);
    repeat (11) wr(`UIP_OFF_DATA, 32'h41);
    rc("full", `UIP_OFF_STAT, 32'h1, 32'h0);
    wr(`UIP_OFF_DATA, 32'h41);
    chk("no_push", 32'(pcnt), 32'h10);
    wr(`UIP_OFF_CTRL, 32'h028);
    wr(`UIP_OFF_RIS, 32'h7ff);
    rc("tx_busy", `UIP_OFF_RIS, 32'h20, 32'h0);
    tx_drain <= 1'b1;
    repeat (20) @(posedge aclk);
    tx_drain <= 1'b0;
    rc("tx_tail", `UIP_OFF_STAT, 32'h4, 32'h0);
    rc("tx_tail_irq", `UIP_OFF_RIS, 32'h20, 32'h0);
    repeat (16) @(posedge aclk);
    rc("tx_idle", `UIP_OFF_RIS, 32'h20, 32'h20);
    rc("stat", `UIP_OFF_STAT, 32'h5, 32'h5);
    close_out();
  end
endmodule : test_uip_status
bind uip_status uip_status_assertions #(.FIFO_DEPTH(FIFO_DEPTH), .LVL_W(LVL_W)) u_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_rvalid(s_axi_rvalid),
  .rx_level(rx_level),
  .rx_pop(rx_pop),
  .tx_level(tx_level),
  .tx_push(tx_push),
  .tx_push_word(tx_push_word),
  .parity_mode(parity_mode),
  .irq(irq)
);

// *** tb/uip_core_model.sv ***
`timescale 1ns/10ps
module uip_core_model #(
  parameter int LVL_W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire uip_pkg::uip_rx_head_t rx_in,
  input wire logic rx_in_vld,
  input wire logic tx_drain,
  output uip_pkg::uip_rx_head_t rx_head,
  output logic [LVL_W-1:0] rx_level,
  output logic [LVL_W-1:0] tx_level,
  output logic tx_shift_busy
);
  uip_pkg::uip_rx_head_t mem_q [16];
  logic [3:0] rd_q;
  logic [3:0] wr_q;
  // Empty FIFO shows a flipped word so a stale head is never taken as data
  assign rx_head = (rx_level != '0) ? mem_q[rd_q] : ~mem_q[rd_q];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= 4'h0;
      wr_q <= 4'h0;
      rx_level <= '0;
    end else begin
      if (rx_in_vld) begin
        mem_q[wr_q] <= rx_in;
      end
      wr_q <= wr_q + 4'(rx_in_vld);
      rd_q <= rd_q + 4'(rx_pop);
      rx_level <= rx_level + LVL_W'(rx_in_vld) - LVL_W'(rx_pop);
    end
  end
  logic [3:0] tail_q;
  // Busy outlasts the FIFO by fifteen cycles, standing in for the last frame and its stop bits
  assign tx_shift_busy = tx_level != '0 || tail_q != 4'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_level <= '0;
      tail_q <= 4'h0;
    end else begin
      tx_level <= tx_level + LVL_W'(tx_push) - LVL_W'(tx_drain && tx_level != '0);
      tail_q <= (tx_level != '0) ? 4'hf : tail_q - 4'(tail_q != 4'h0);
    end
  end
endmodule : uip_core_model

// *** tb/uip_status_assertions.sv ***
`timescale 1ns/10ps
module uip_status_assertions #(
  parameter int FIFO_DEPTH = 16,
  parameter int LVL_W = 5
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [LVL_W-1:0] rx_level,
  input wire logic rx_pop,
  input wire logic [LVL_W-1:0] tx_level,
  input wire logic tx_push,
  input wire uip_pkg::uip_tx_push_t tx_push_word,
  input wire uip_pkg::uip_parity_t parity_mode,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_par(logic [2:0] m, logic b);
    tx_push && parity_mode == m |-> tx_push_word.parity_bit == b;
  endproperty
  a_par_even: assert property (p_par(3'h1, ^tx_push_word.data)) else $error("even bit");
  a_par_odd: assert property (p_par(3'h2, ~^tx_push_word.data)) else $error("odd bit");
  a_par_one: assert property (p_par(3'h3, 1'b1)) else $error("forced one bit");
  a_par_zero: assert property (p_par(3'h4, 1'b0)) else $error("forced zero bit");
  a_push_space: assert property (tx_push |-> tx_level < FIFO_DEPTH) else $error("full push");
  a_push_resp: assert property (tx_push |-> $rose(s_axi_bvalid)) else $error("push time");
  a_pop_read: assert property (rx_pop |-> $rose(s_axi_rvalid) && rx_level != 0) else $error("pop");
  // Only a mask or clear write may lower the line
  a_irq_fall: assert property ($fell(irq) |-> $past(s_axi_bvalid)) else $error("irq fell alone");
  c_irq: cover property ($rose(irq));
  c_push: cover property (tx_push);
  c_pop: cover property (rx_pop);
endmodule : uip_status_assertions
